// file: design/mux_bus_map.vh
// Register offsets, field positions, reset value, port codes and read buffer depth of the bus unit.
`ifndef MUX_BUS_MAP_VH
`define MUX_BUS_MAP_VH
`define OFS_BUS_OPTION 12'h000
`define OFS_REQ_ADDR 12'h004
`define OFS_REQ_WDATA 12'h008
`define OFS_REQ_CTRL 12'h00c
`define OFS_STATUS 12'h010
`define OFS_RDATA 12'h014
`define OFS_FIRST 12'h018
`define OPT_BE_RDMASK 0
`define OPT_BE16_RDMASK 1
`define OPT_STRB_RD 2
`define OPT_STRB_WR 3
`define OPT_BIG_END 4
`define OPT_DBURST 5
`define OPT_RESET 32'h0000_001b
`define CTL_WRITE 0
`define CTL_SIZE_LO 1
`define CTL_SIZE_HI 2
`define CTL_PORT_LO 3
`define CTL_PORT_HI 4
`define CTL_MISS 5
`define CTL_IFETCH 6
`define CTL_GO 7
`define CTL_BYTES_LO 8
`define CTL_BYTES_HI 10
`define ST_BUSY 0
`define ST_DONE 1
`define ST_FAULT 2
`define ST_EXC 3
`define PORT32 2'h0
`define PORT16 2'h1
`define PORT8 2'h2
`define PAGE_LO 8
`define RDBUF_DEPTH 16
`endif

// file: design/lane_decode.v
// Lane pattern decoder for the start of a bus transaction.
`timescale 1ns/1ps
`default_nettype none
module lane_decode (
	input wire [1:0] size, // Access size: 0 byte, 1 half, 2 word.
	input wire [1:0] addr_lo, // Low two bits of the byte address.
	input wire big_end, // Big-endian byte numbering.
	output reg [3:0] lanes_n // Active-low lanes touched.
);
	// Lane 3 is bits 31..24; big-endian maps offset 0 there.
	always @* begin
		lanes_n = 4'hf;
		case (size)
		2'h0: lanes_n[big_end ? 2'd3 - addr_lo : addr_lo] = 1'b0;
		2'h1: begin
			if (addr_lo[1] ^ big_end) begin
				lanes_n[3] = 1'b0;
				lanes_n[2] = 1'b0;
			end else begin
				lanes_n[1] = 1'b0;
				lanes_n[0] = 1'b0;
			end
		end
		default: lanes_n = 4'h0;
		endcase
	end
endmodule // lane_decode
`default_nettype wire

// file: design/mux_bus_unit.v
// Multiplexed address/data bus master with APB control registers.
// How it works
// - One 32-bit bus carries address in one cycle and data in others.
// - First phase drives address 31..4 and lane strobes, latched by ALE.
// - Active-low lane strobes 3..0 mark bytes 31..24 down to 7..0.
// - For narrow ports lane strobes show all bytes the whole transaction uses.
// - Lane strobes held inactive on reads when read mask is disabled.
// - Writes drive write buffer data; reads fill the read buffer.
// - Narrow ports use upper lanes big-endian, lower lanes little-endian.
// - 32-bit ports: address bits 3..2 give word or count from 00.
// - 16-bit ports: address bits 3..1 give halfword or count from 000.
// - 8-bit ports: address bits 3..0 give byte or count per datum.
// - ALE high while the bus holds address and lane strobes.
// - Read drive enable asserts after bus release; negated on writes, idle.
// - Burst request only for cache-miss reads: instruction always, data optionally.
// - On writes the pin hints a back-to-back write in same 256 page.
// - Read strobe for reads, write strobe for writes.
// - Write acknowledge advances to next datum or ends transaction.
// - Capture input loads the bus datum into the read buffer.
// - Bus fault ends transaction; on reads it raises a bus error exception.
// - Half-port strobe 1 marks high byte, 0 low byte; maskable on reads.
// - Final-datum asserts with strobe for singles, after next-to-last otherwise.
// - Datum strobe pulses per datum, enabled per direction; writes after reset.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mux_bus_map.vh"
module mux_bus_unit (
	input wire pclk, // Bus clock.
	input wire presetn, // Asynchronous reset, active low.
	input wire psel, // APB select.
	input wire penable, // APB access phase.
	input wire pwrite, // APB write.
	input wire [11:0] paddr, // APB byte address.
	input wire [31:0] pwdata, // APB write data.
	output wire pready, // APB ready, always high.
	output reg [31:0] prdata, // APB read data.
	output wire pslverr, // APB error on unmapped address.
	input wire [31:0] ad_in, // Shared bus level seen at the pins.
	output reg [31:0] ad_out, // Shared bus drive value.
	output reg ad_oe_n, // Shared bus output enable, low drives.
	output reg [3:0] addr_low, // Dedicated low address outputs.
	output reg ale, // Address latch strobe, active high.
	output reg read_drive_enable_n, // Memory may drive the bus.
	output reg burst_or_page_write_hint_n, // Burst request or page hint.
	output reg rd_n, // Read strobe.
	output reg wr_n, // Write strobe.
	input wire ack_n, // Acknowledge from memory.
	input wire read_buffer_capture_n, // Datum valid, load it.
	input wire bus_fault_input_n, // Bus error from memory.
	output reg [3:0] lane_select_strobes_n, // Lane strobes on the bus.
	output reg [1:0] half_port_lane_strobes_n, // 16-bit port lane strobes.
	output reg last_n, // Final datum of the transaction.
	output reg datum_strobe_n, // One pulse per datum.
	output reg bus_error_exc // Read bus error exception, a pulse.
);
	localparam S_IDLE = 3'd0;
	localparam S_ADDR = 3'd1;
	localparam S_TURN = 3'd2;
	localparam S_DATA = 3'd3;
	localparam S_END = 3'd4;

	reg [2:0] state;
	reg [31:0] bus_option;
	reg [31:0] req_addr;
	reg [31:0] req_wdata;
	reg [10:0] req_ctrl;
	reg done;
	reg fault;
	reg [4:0] count;
	reg [4:0] total;
	reg [3:0] rd_ptr;
	reg [3:0] wr_ptr;
	reg [31:0] rdbuf [0:`RDBUF_DEPTH-1];
	reg [31:0] prev_waddr;
	reg prev_was_write;
	wire [3:0] dec_n;
	wire is_write = req_ctrl[`CTL_WRITE];
	wire big_end = bus_option[`OPT_BIG_END];
	wire burst_rd = !is_write && req_ctrl[`CTL_MISS] &&
		(req_ctrl[`CTL_IFETCH] || bus_option[`OPT_DBURST]);
	wire apb_wr = psel && penable && pwrite;
	wire apb_rd = psel && penable && !pwrite;
	wire go = apb_wr && paddr == `OFS_REQ_CTRL && pwdata[`CTL_GO];
	// The go write reaches req_ctrl only at this edge, so the address
	// phase decodes size and port straight from the write data.
	wire [10:0] ctrl_now = (state == S_IDLE && go) ? pwdata[10:0] :
		req_ctrl;
	wire [1:0] port = ctrl_now[`CTL_PORT_HI:`CTL_PORT_LO];
	wire strobe_on = is_write ? bus_option[`OPT_STRB_WR] :
		bus_option[`OPT_STRB_RD];
	wire mapped = paddr < `OFS_FIRST && paddr[1:0] == 2'h0;
	wire [4:0] next_count = count + 5'd1;

	// Number of data in the transaction, from port width and request.
	function [4:0] data_count;
		input [1:0] p;
		input burst;
		input [2:0] nbytes;
		begin
			if (burst)
				data_count = (p == `PORT32) ? 5'd4 :
					(p == `PORT16) ? 5'd8 : 5'd16;
			else if (p == `PORT16 && nbytes > 3'd2)
				data_count = 5'd2;
			else if (p == `PORT8 && nbytes > 3'd1)
				data_count = {2'b00, nbytes};
			else
				data_count = 5'd1;
		end
	endfunction

	// Low address outputs for datum number n of the current transaction.
	function [3:0] low_addr;
		input [1:0] p;
		input burst;
		input [3:0] base;
		input [4:0] n;
		begin
			case (p)
			`PORT32: low_addr = burst ? {n[1:0], 2'b00} :
				{base[3:2], 2'b00};
			`PORT16: low_addr = burst ? {n[2:0], 1'b0} :
				{base[3:2], n[0] | base[1], 1'b0};
			default: low_addr = burst ? n[3:0] :
				base + n[3:0];
			endcase
		end
	endfunction

	// Lanes follow the request being started, not the one before it.
	lane_decode u_lane (
		.size(ctrl_now[`CTL_SIZE_HI:`CTL_SIZE_LO]),
		.addr_lo(req_addr[1:0]),
		.big_end(big_end),
		.lanes_n(dec_n)
	);

	// Every access completes in its first access cycle; no wait states.
	assign pready = 1'b1;
	// Unmapped or unaligned offsets answer with an error and read as zero.
	assign pslverr = psel && penable && !mapped;

	// Register writes; the done and fault flags favour hardware setting them.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_option <= `OPT_RESET;
			req_addr <= 32'h0;
			req_wdata <= 32'h0;
			req_ctrl <= 11'h0;
		end else if (apb_wr && state == S_IDLE) begin
			case (paddr)
			`OFS_BUS_OPTION: bus_option <= pwdata;
			`OFS_REQ_ADDR: req_addr <= pwdata;
			`OFS_REQ_WDATA: req_wdata <= pwdata;
			`OFS_REQ_CTRL: req_ctrl <= pwdata[10:0];
			default: ;
			endcase
		end
	end

	// Register reads; reading the data port pops the read buffer.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			rd_ptr <= 4'h0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
			`OFS_BUS_OPTION: prdata <= bus_option;
			`OFS_REQ_ADDR: prdata <= req_addr;
			`OFS_REQ_WDATA: prdata <= req_wdata;
			`OFS_REQ_CTRL: prdata <= {21'h0, req_ctrl};
			`OFS_STATUS: prdata <= {28'h0, bus_error_exc, fault, done,
				state != S_IDLE};
			`OFS_RDATA: prdata <= rdbuf[rd_ptr];
			default: prdata <= 32'h0;
			endcase
		end else if (apb_rd && paddr == `OFS_RDATA) begin
			rd_ptr <= rd_ptr + 4'h1;
		end else if (go && state == S_IDLE) begin
			// A new transaction refills from slot 0, so popping restarts there.
			rd_ptr <= 4'h0;
		end
	end

	// The read buffer takes each datum the memory marks valid.
	always @(posedge pclk) begin
		if (state == S_DATA && !is_write && !read_buffer_capture_n)
			rdbuf[wr_ptr] <= ad_in;
	end

	// Bus sequencer: address phase, turnaround, data beats, end.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			count <= 5'h0;
			total <= 5'h1;
			wr_ptr <= 4'h0;
			done <= 1'b0;
			fault <= 1'b0;
			bus_error_exc <= 1'b0;
			prev_waddr <= 32'h0;
			prev_was_write <= 1'b0;
		end else begin
			bus_error_exc <= 1'b0;
			if (apb_wr && paddr == `OFS_STATUS) begin
				done <= done & ~pwdata[`ST_DONE];
				fault <= fault & ~pwdata[`ST_FAULT];
			end
			case (state)
			S_IDLE: if (go) begin
				state <= S_ADDR;
				count <= 5'h0;
				wr_ptr <= 4'h0;
				total <= data_count(pwdata[`CTL_PORT_HI:`CTL_PORT_LO],
					!pwdata[`CTL_WRITE] && pwdata[`CTL_MISS] &&
					(pwdata[`CTL_IFETCH] || bus_option[`OPT_DBURST]),
					pwdata[`CTL_BYTES_HI:`CTL_BYTES_LO]);
			end
			S_ADDR: begin
				// Writes drive data at once; reads need a release cycle.
				state <= is_write ? S_DATA : S_TURN;
			end
			S_TURN: state <= S_DATA;
			S_DATA: begin
				if (!bus_fault_input_n) begin
					// A cut transfer skips the acknowledge wait entirely.
					state <= S_IDLE;
					fault <= 1'b1;
					bus_error_exc <= !is_write;
					done <= 1'b1;
					prev_was_write <= is_write;
					prev_waddr <= req_addr;
				end else if (is_write ? !ack_n : !read_buffer_capture_n) begin
					count <= next_count;
					if (!is_write)
						wr_ptr <= wr_ptr + 4'h1;
					if (next_count == total)
						state <= S_END;
				end
			end
			S_END: begin
				// Reads finish only on acknowledge; a write has had its own.
				if (is_write || !ack_n) begin
					state <= S_IDLE;
					done <= 1'b1;
					prev_was_write <= is_write;
					prev_waddr <= req_addr;
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end

	// Pin drivers, registered from the next state so outputs stay glitch free.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ad_out <= 32'h0;
			ad_oe_n <= 1'b1;
			addr_low <= 4'h0;
			ale <= 1'b0;
			read_drive_enable_n <= 1'b1;
			burst_or_page_write_hint_n <= 1'b1;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			lane_select_strobes_n <= 4'hf;
			half_port_lane_strobes_n <= 2'h3;
			last_n <= 1'b1;
			datum_strobe_n <= 1'b1;
		end else begin
			ale <= state == S_IDLE && go;
			datum_strobe_n <= 1'b1;
			case (state)
			S_IDLE: if (go) begin
				// Address phase: upper address with lane strobes on low bits.
				ad_out <= {req_addr[31:4], dec_n};
				ad_oe_n <= 1'b0;
				addr_low <= low_addr(port, 1'b0, req_addr[3:0], 5'h0);
			end
			S_ADDR: begin
				ad_out <= req_wdata;
				ad_oe_n <= !is_write; // Release before memory drives.
				lane_select_strobes_n <= (!is_write &&
					!bus_option[`OPT_BE_RDMASK]) ? 4'hf : dec_n;
				// Narrow lanes ignore reverse endian; set by big_end only.
				half_port_lane_strobes_n <= (!is_write &&
					!bus_option[`OPT_BE16_RDMASK]) ? 2'h3 :
					(big_end ? dec_n[3:2] : dec_n[1:0]);
				addr_low <= low_addr(port, burst_rd, req_addr[3:0], 5'h0);
				rd_n <= is_write;
				wr_n <= !is_write;
				read_drive_enable_n <= 1'b1;
				burst_or_page_write_hint_n <= is_write ?
					!(prev_was_write && prev_waddr[31:`PAGE_LO] ==
					req_addr[31:`PAGE_LO]) : !burst_rd;
				last_n <= !(total == 5'h1);
				datum_strobe_n <= !strobe_on;
			end
			S_TURN: read_drive_enable_n <= 1'b0;
			S_DATA: begin
				if (!bus_fault_input_n) begin
					// Everything is released at once; no end cycle follows.
					rd_n <= 1'b1;
					wr_n <= 1'b1;
					last_n <= 1'b1;
					ad_oe_n <= 1'b1;
					read_drive_enable_n <= 1'b1;
					burst_or_page_write_hint_n <= 1'b1;
					lane_select_strobes_n <= 4'hf;
					half_port_lane_strobes_n <= 2'h3;
				end else if (is_write ? !ack_n : !read_buffer_capture_n) begin
					if (next_count == total) begin
						wr_n <= 1'b1;
						// A read keeps last asserted until its strobe ends.
						if (is_write)
							last_n <= 1'b1;
						ad_oe_n <= 1'b1;
					end else begin
						// Next write datum: 8-bit ports repeat the next byte on all lanes; 16-bit ports repeat the low halfword.
						addr_low <= low_addr(port, burst_rd,
							req_addr[3:0], next_count);
						last_n <= !(next_count + 5'h1 == total);
						datum_strobe_n <= !strobe_on;
						if (is_write)
							ad_out <= (port == `PORT16) ?
								{req_wdata[15:0], req_wdata[15:0]} :
								{4{req_wdata[8*next_count[1:0] +: 8]}};
					end
				end
			end
			S_END: if (is_write || !ack_n) begin
				rd_n <= 1'b1;
				last_n <= 1'b1;
				read_drive_enable_n <= 1'b1;
				burst_or_page_write_hint_n <= 1'b1;
				lane_select_strobes_n <= 4'hf;
				half_port_lane_strobes_n <= 2'h3;
			end
			default: ;
			endcase
		end
	end
endmodule // mux_bus_unit
`default_nettype wire

// file: dv/mux_bus_unit_chk.sv
// Pin-level checks on the multiplexed bus unit.
`timescale 1ns/1ps
`default_nettype none
module mux_bus_unit_chk (
	input wire logic pclk, // Clock.
	input wire logic presetn, // Reset, active low.
	input wire logic ad_oe_n, // Bus drive enable.
	input wire logic ale, // Address latch strobe.
	input wire logic read_drive_enable_n, // Memory may drive.
	input wire logic rd_n, // Read strobe.
	input wire logic wr_n, // Write strobe.
	input wire logic last_n, // Final datum.
	input wire logic datum_strobe_n // Datum pulse.
);
	// All checks share the bus clock and stay quiet in reset.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ale_pulse: assert property (ale |=> !ale)
		else $error("ale longer than one cycle");
	a_addr_drive: assert property (ale |-> !ad_oe_n)
		else $error("address phase not driven");
	a_strobe_next: assert property (ale |=> (rd_n != wr_n))
		else $error("no single strobe after ale");
	a_rde_idle: assert property (rd_n |-> read_drive_enable_n)
		else $error("drive enable outside a read");
	a_rde_float: assert property (!read_drive_enable_n |-> ad_oe_n)
		else $error("drive enable while device drives");
	a_rde_delay: assert property ($fell(rd_n) |->
		read_drive_enable_n ##1 !read_drive_enable_n)
		else $error("drive enable timing wrong");
	a_wr_drive: assert property (!wr_n |-> !ad_oe_n)
		else $error("write data not driven");
	a_rd_float: assert property (!rd_n |-> ad_oe_n)
		else $error("bus driven during read");
	a_last_strb: assert property (!last_n |-> !(rd_n && wr_n))
		else $error("last without strobe");
	a_ds_pulse: assert property (!datum_strobe_n |=> datum_strobe_n)
		else $error("datum strobe too long");
	a_last_hold: assert property ((!rd_n && !last_n) |=> (rd_n || !last_n))
		else $error("last released before read strobe");
	c_write: cover property ($fell(wr_n));
	c_last_rd: cover property (!last_n && !rd_n);
	c_ds_rd: cover property (!datum_strobe_n && !rd_n);
endmodule // mux_bus_unit_chk
`default_nettype wire

// file: dv/mux_bus_mem.sv
// Behavioural memory on the far side of the multiplexed bus.
`timescale 1ns/1ps
`default_nettype none
module mux_bus_mem (
	input wire logic pclk, // Clock.
	input wire logic [31:0] ad_out, // Device drive value.
	input wire logic ad_oe_n, // Device drives when low.
	input wire logic [3:0] addr_low, // Low address.
	input wire logic ale, // Address latch strobe.
	input wire logic rde_n, // Memory may drive.
	input wire logic rd_n, // Read strobe.
	input wire logic wr_n, // Write strobe.
	input wire logic last_n, // Final datum.
	input wire logic hint_n, // Burst or page hint.
	input wire logic ds_n, // Datum strobe.
	input wire logic [3:0] lanes_n, // Lane strobes.
	input wire logic [3:0] wt, // Stall cycles per datum.
	input wire logic fault_en, // Answer with a bus fault.
	output logic [31:0] ad_in, // Bus level.
	output logic ack_n, // Acknowledge.
	output logic cap_n, // Read buffer capture.
	output logic flt_n // Bus fault.
);
	logic [31:0] lvl = '0, latch, q, wd;
	logic [3:0] al [0:15];
	logic [15:0] lb;
	logic [3:0] lanes_acc;
	logic hint, dn;
	int beats, ds_cnt;
	// A released bus shows a changing pattern, never a held value.
	assign ad_in = !ad_oe_n ? ad_out : !rde_n ? q : ~lvl;
	// Latch the address phase and count strobes per transaction.
	always @(posedge pclk) begin
		lvl <= ad_in;
		if (ale) begin
			latch <= ad_in;
			ds_cnt <= 0;
			lanes_acc <= 4'hf;
		end else begin
			ds_cnt <= ds_cnt + (ds_n ? 0 : 1);
			if (!rd_n || !wr_n) lanes_acc <= lanes_acc & lanes_n;
		end
	end
	// One datum per loop; a gap cycle lets last_n settle before the next.
	initial begin
		ack_n = 1'b1;
		cap_n = 1'b1;
		flt_n = 1'b1;
		forever begin
			@(posedge pclk);
			if (!rd_n || !wr_n) begin
				hint = hint_n;
				beats = 0;
				while (!rd_n && rde_n) @(posedge pclk);
				dn = 1'b0;
				while (!dn) begin
					repeat (wt) @(posedge pclk);
					if (fault_en) flt_n <= 1'b0;
					else if (!rd_n) begin
						q <= ~{latch[31:4], addr_low[3:2], 2'b00};
						cap_n <= 1'b0;
					end else ack_n <= 1'b0;
					@(posedge pclk);
					al[beats] = addr_low;
					lb[beats] = last_n;
					if (!wr_n) wd = ad_in;
					beats++;
					dn = !last_n || fault_en || (rd_n && wr_n);
					cap_n <= 1'b1;
					flt_n <= 1'b1;
					ack_n <= 1'b1;
					@(posedge pclk);
				end
				if (!rd_n && !fault_en) begin
					ack_n <= 1'b0;
					while (!rd_n) @(posedge pclk);
					ack_n <= 1'b1;
				end
			end
		end
	end
endmodule // mux_bus_mem
`default_nettype wire

// file: dv/mux_bus_unit_tb.sv
// Register-driven testbench for the multiplexed bus unit.
`timescale 1ns/1ps
`default_nettype none
`include "mux_bus_map.vh"
module mux_bus_unit_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, ad_in, ad_out, r;
	logic ad_oe_n, ale, rde_n, hint_n, rd_n, wr_n, ack_n, cap_n, flt_n;
	logic last_n, ds_n, exc, fault_en;
	logic [3:0] addr_low, lanes_n, wt;
	logic [1:0] hl_n;
	int error_cnt, num_checks, cyc, exc_cnt;
	mux_bus_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .ad_in(ad_in),
		.ad_out(ad_out), .ad_oe_n(ad_oe_n), .addr_low(addr_low), .ale(ale),
		.read_drive_enable_n(rde_n), .burst_or_page_write_hint_n(hint_n),
		.rd_n(rd_n), .wr_n(wr_n), .ack_n(ack_n), .read_buffer_capture_n(cap_n),
		.bus_fault_input_n(flt_n), .lane_select_strobes_n(lanes_n),
		.half_port_lane_strobes_n(hl_n), .last_n(last_n),
		.datum_strobe_n(ds_n), .bus_error_exc(exc));
	mux_bus_mem u_mem (.pclk(pclk), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
		.addr_low(addr_low), .ale(ale), .rde_n(rde_n), .rd_n(rd_n),
		.wr_n(wr_n), .last_n(last_n), .hint_n(hint_n), .ds_n(ds_n),
		.lanes_n(lanes_n), .wt(wt), .fault_en(fault_en), .ad_in(ad_in),
		.ack_n(ack_n), .cap_n(cap_n), .flt_n(flt_n));
	// Clock at 250 MHz.
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Count exceptions and cut a hung run short.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		exc_cnt <= exc_cnt + (exc ? 1 : 0);
		if (cyc == 20000) begin
			error_cnt++;
			close_out;
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	// One APB transfer; holds the request until pready is seen high.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Start a transaction and poll until the unit is idle again.
	task run(input logic [31:0] a, input logic [31:0] c);
		apb(1'b1, `OFS_REQ_ADDR, a);
		apb(1'b1, `OFS_REQ_CTRL, c);
		do apb(1'b0, `OFS_STATUS, 32'h0); while (r[`ST_BUSY] !== 1'b0);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Main sequence: reset, writes, reads, a burst and a fault.
	initial begin
		{presetn, psel, penable, pwrite, fault_en} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		wt = 4'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OFS_BUS_OPTION, 32'h0);
		chk(r, `OPT_RESET);
		chk(32'({ale, rd_n, wr_n, rde_n, ds_n}), 32'h0f);
		apb(1'b0, 12'h018, 32'h0);
		chk(32'({err, r[0]}), 32'h2);
		$display("test reset done");
		apb(1'b1, `OFS_REQ_WDATA, 32'hcafe_f00d);
		run(32'h0001_2344, 32'h85);
		chk(u_mem.wd, 32'hcafe_f00d);
		chk(u_mem.latch, 32'h0001_2340);
		chk(32'(u_mem.al[0][3:2]), 32'h1);
		chk(32'(u_mem.ds_cnt), 32'h1);
		chk(32'(u_mem.hint), 32'h1);
		run(32'h0001_2300, 32'h48d);
		chk(32'(u_mem.hint), 32'h0);
		chk(32'(u_mem.beats), 32'h2);
		chk(32'({u_mem.al[1][3:1], u_mem.al[0][3:1]}), 32'h08);
		chk(32'(u_mem.lb[1:0]), 32'h1);
		run(32'h0001_2300, 32'h395);
		chk(32'({u_mem.al[2], u_mem.al[1], u_mem.al[0]}), 32'h210);
		chk(32'(u_mem.beats), 32'h3);
		$display("test writes done");
		run(32'h0001_2348, 32'h84);
		apb(1'b0, `OFS_RDATA, 32'h0);
		chk(r, ~32'h0001_2348);
		chk(32'(u_mem.lanes_acc), 32'h0);
		chk(32'(u_mem.ds_cnt), 32'h0);
		chk(32'(u_mem.hint), 32'h1);
		apb(1'b1, `OFS_BUS_OPTION, 32'h1e);
		wt <= 4'h3;
		run(32'h0001_2340, 32'he4);
		chk(32'(u_mem.hint), 32'h0);
		chk(32'(u_mem.beats), 32'h4);
		chk(32'(u_mem.lanes_acc), 32'hf);
		chk(32'(u_mem.ds_cnt), 32'h4);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, `OFS_RDATA, 32'h0);
			chk(r, ~(32'h0001_2340 | 32'(i << 2)));
		end
		$display("test reads done");
		fault_en <= 1'b1;
		run(32'h0001_2350, 32'h84);
		chk(32'(r[`ST_FAULT]), 32'h1);
		chk(32'(exc_cnt), 32'h1);
		$display("test fault done");
		close_out;
	end
endmodule // mux_bus_unit_tb
bind mux_bus_unit mux_bus_unit_chk u_chk (.pclk(pclk), .presetn(presetn),
	.ad_oe_n(ad_oe_n), .ale(ale), .read_drive_enable_n(read_drive_enable_n),
	.rd_n(rd_n), .wr_n(wr_n), .last_n(last_n),
	.datum_strobe_n(datum_strobe_n));
`default_nettype wire
